// file: hw/rtcram_top.sv
// byte-wide static ram whose top eight bytes hold a calendar clock
`include "rtcram_params.svh"
`default_nettype none
module rtcram_top
  import rtcram_pkg::*;
#(
  parameter int unsigned CYCLES_PER_SEC = `RTC_SECOND_NS / `RTC_CLK_PERIOD_NS
) (
  input wire logic clk,
  input wire logic rst,
  input wire rtcram_addr_t addr_in,
  input wire rtcram_byte_t data_bus_in,
  output rtcram_byte_t data_bus_out,
  output logic data_bus_oe,
  input wire logic chip_en_n,
  input wire logic write_en_n,
  input wire logic out_en_n,
  input wire logic power_fail_trip
);
  rtcram_byte_t mem [0:`RTC_RAM_WORDS-1];
  rtcram_byte_t clk_reg_q [0:7];
  rtcram_byte_t cnt_val [1:7];
  rtcram_byte_t cnt_max [1:7];
  logic cnt_inc [1:7];
  logic cnt_wrap [1:7];
  localparam rtcram_byte_t RST_TAB [1:7] = '{`RTC_RST_SEC, `RTC_RST_MIN, `RTC_RST_HOUR,
    `RTC_RST_WDAY, `RTC_RST_DATE, `RTC_RST_MONTH, `RTC_RST_YEAR};
  localparam rtcram_byte_t MIN_TAB [1:7] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};

  logic bus_sel;
  logic wr_act;
  logic clk_hit;
  logic [2:0] idx;
  logic halt;
  logic load_q;
  logic copy_q;
  logic tick_q;
  logic [31:0] div_q;
  logic [31:0] period;
  logic [31:0] cal_adj;

  assign bus_sel = !power_fail_trip && !chip_en_n; // RQ9
  assign wr_act = bus_sel && !write_en_n; // RQ13
  assign clk_hit = addr_in >= `RTC_CLK_BASE; // RQ3 RQ16
  assign idx = addr_in[2:0];
  assign halt = clk_reg_q[RTCRAM_IDX_CTRL][`RTC_CTL_READ] ||
    clk_reg_q[RTCRAM_IDX_CTRL][`RTC_CTL_WRITE]; // RQ15

  function automatic logic is_leap(input rtcram_byte_t y);
    if (y[4]) begin
      is_leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
    end else begin
      is_leap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
    end
  endfunction : is_leap

  function automatic rtcram_byte_t month_days(input rtcram_byte_t m, input rtcram_byte_t y);
    unique case (m)
      `RTC_FEB: month_days = is_leap(y) ? 8'h29 : 8'h28; // RQ5
      8'h04, 8'h06, 8'h09, 8'h11: month_days = 8'h30;
      default: month_days = 8'h31;
    endcase
  endfunction : month_days

  // array storage: written each cycle of an active write, last data wins
  always_ff @(posedge clk) begin
    if (wr_act && !clk_hit) begin
      mem[addr_in] <= data_bus_in; // RQ1 RQ10 RQ13
    end
  end

  // read path; a low write strobe floats the outputs whatever out_en_n says
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      data_bus_oe <= 1'b0;
      data_bus_out <= 8'h00;
    end else begin
      data_bus_oe <= bus_sel && write_en_n && !out_en_n; // RQ12 RQ14 RQ9
      data_bus_out <= clk_hit ? clk_reg_q[idx] : mem[addr_in]; // RQ2 RQ12
    end
  end

  // clock register bytes: host writes take priority over the copy
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clk_reg_q[0] <= `RTC_RST_CTRL;
      for (int k = 1; k < 8; k++) begin
        clk_reg_q[k] <= RST_TAB[k];
      end
    end else begin
      for (int k = 0; k < 8; k++) begin
        if (wr_act && clk_hit && idx == k[2:0]) begin
          clk_reg_q[k] <= data_bus_in; // RQ2
        end else if (copy_q && k != 0) begin
          clk_reg_q[k] <= cnt_val[k]; // RQ7 RQ6 RQ8
        end
      end
    end
  end

  // clearing the write bit hands the register values to the counters
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      load_q <= 1'b0;
    end else begin
      load_q <= wr_act && clk_hit && idx == RTCRAM_IDX_CTRL && !data_bus_in[`RTC_CTL_WRITE] &&
        clk_reg_q[RTCRAM_IDX_CTRL][`RTC_CTL_WRITE];
    end
  end

  // second divider; calibration trims the period, sign bit shortens it
  assign cal_adj = 32'(clk_reg_q[RTCRAM_IDX_CTRL][`RTC_CTL_CAL_HI:`RTC_CTL_CAL_LO]) *
    32'(`RTC_CAL_STEP);
  assign period = clk_reg_q[RTCRAM_IDX_CTRL][`RTC_CTL_SIGN] ?
    CYCLES_PER_SEC - cal_adj : CYCLES_PER_SEC + cal_adj; // RQ11

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_q <= 32'h0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= div_q >= period - 32'h1;
      div_q <= (div_q >= period - 32'h1) ? 32'h0 : div_q + 32'h1; // RQ11
    end
  end

  // copy one cycle after the counters step, unless software holds it off
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      copy_q <= 1'b0;
    end else begin
      copy_q <= tick_q && !halt; // RQ7 RQ15
    end
  end

  always_comb begin
    cnt_inc[RTCRAM_IDX_SEC] = tick_q && !clk_reg_q[RTCRAM_IDX_CTRL][`RTC_CTL_WRITE];
    cnt_inc[RTCRAM_IDX_MIN] = cnt_wrap[RTCRAM_IDX_SEC];
    cnt_inc[RTCRAM_IDX_HOUR] = cnt_wrap[RTCRAM_IDX_MIN];
    cnt_inc[RTCRAM_IDX_WDAY] = cnt_wrap[RTCRAM_IDX_HOUR];
    cnt_inc[RTCRAM_IDX_DATE] = cnt_wrap[RTCRAM_IDX_HOUR];
    cnt_inc[RTCRAM_IDX_MONTH] = cnt_wrap[RTCRAM_IDX_DATE];
    cnt_inc[RTCRAM_IDX_YEAR] = cnt_wrap[RTCRAM_IDX_MONTH];
    cnt_max[RTCRAM_IDX_SEC] = `RTC_MAX_SEC; // RQ4
    cnt_max[RTCRAM_IDX_MIN] = `RTC_MAX_MIN;
    cnt_max[RTCRAM_IDX_HOUR] = `RTC_MAX_HOUR;
    cnt_max[RTCRAM_IDX_WDAY] = `RTC_MAX_WDAY;
    cnt_max[RTCRAM_IDX_DATE] = month_days(cnt_val[RTCRAM_IDX_MONTH],
      cnt_val[RTCRAM_IDX_YEAR]); // RQ5
    cnt_max[RTCRAM_IDX_MONTH] = `RTC_MAX_MONTH;
    cnt_max[RTCRAM_IDX_YEAR] = `RTC_MAX_YEAR;
  end

  for (genvar g = 1; g < 8; g++) begin : g_cnt
    rtcram_bcd_ctr #(
      .RST_VAL(RST_TAB[g])
    ) u_ctr (
      .clk(clk),
      .rst(rst),
      .inc(cnt_inc[g]),
      .load(load_q),
      .load_val(clk_reg_q[g]),
      .min_val(MIN_TAB[g]),
      .max_val(cnt_max[g]),
      .val_q(cnt_val[g]),
      .wrap(cnt_wrap[g])
    );
  end

  default clocking dcb @(posedge clk); endclocking
  default disable iff (rst);

  sequence host_clk_wr_s(logic [2:0] i);
    wr_act && clk_hit && idx == i;
  endsequence

  sequence feb_end_s;
    cnt_val[RTCRAM_IDX_MONTH] == `RTC_FEB && cnt_val[RTCRAM_IDX_DATE] == 8'h28 &&
      !is_leap(cnt_val[RTCRAM_IDX_YEAR]) && cnt_wrap[RTCRAM_IDX_HOUR];
  endsequence

  pf_float_a: assert property ( // RQ9
    power_fail_trip |=> !data_bus_oe) else $error("outputs driven during power fail");

  write_float_a: assert property ( // RQ14
    !write_en_n |=> !data_bus_oe) else $error("outputs driven during write");

  // compare with the byte as it stood when sampled; a copy may change it just after
  read_drive_a: assert property ( // RQ12
    bus_sel && write_en_n && !out_en_n |=> data_bus_oe && data_bus_out ==
    $past(clk_hit ? clk_reg_q[idx] : mem[addr_in]))
    else $error("read data wrong or not driven");

  ram_store_a: assert property ( // RQ10
    wr_act && !clk_hit |=> mem[$past(addr_in)] == $past(data_bus_in))
    else $error("ram write lost");

  pf_block_a: assert property ( // RQ9
    power_fail_trip && !chip_en_n && !write_en_n && !clk_hit && !copy_q
    |=> mem[$past(addr_in)] == $past(mem[addr_in])) else $error("write accepted in power fail");

  copy_sec_a: assert property ( // RQ7
    tick_q && !halt ##1 !(wr_act && clk_hit && idx == 3'(RTCRAM_IDX_SEC))
    |=> clk_reg_q[RTCRAM_IDX_SEC] == $past(cnt_val[RTCRAM_IDX_SEC]))
    else $error("seconds not copied after tick");

  host_wins_a: assert property ( // RQ2
    host_clk_wr_s(3'(RTCRAM_IDX_SEC)) |=> clk_reg_q[RTCRAM_IDX_SEC] == $past(data_bus_in))
    else $error("host write to clock byte lost");

  halt_hold_a: assert property ( // RQ15
    tick_q && halt |=> !copy_q) else $error("copy while halted");

  ctrl_kept_a: assert property ( // RQ6
    copy_q && !(wr_act && clk_hit && idx == 3'(RTCRAM_IDX_CTRL))
    |=> $stable(clk_reg_q[RTCRAM_IDX_CTRL]))
    else $error("control byte overwritten by copy");

  feb_wrap_a: assert property ( // RQ5
    feb_end_s and !load_q |=> cnt_val[RTCRAM_IDX_DATE] == 8'h01 &&
    cnt_val[RTCRAM_IDX_MONTH] == 8'h03) else $error("february rollover wrong");

  hour_range_a: assert property ( // RQ4
    cnt_val[RTCRAM_IDX_HOUR] <= `RTC_MAX_HOUR && $past(cnt_wrap[RTCRAM_IDX_HOUR]) &&
    !$past(load_q) |->
    cnt_val[RTCRAM_IDX_HOUR] == 8'h00) else $error("hour did not wrap to zero");

endmodule : rtcram_top
`default_nettype wire

// file: hw/rtcram_params.svh
// constants for the battery-backed ram with calendar clock
// Notes on behaviour
// [RQ1] behaves as a plain 2K x 8 static ram: 11 address, 8 data lines
// [RQ2] clock bytes use the same bus cycles as any other ram byte
// [RQ3] clock registers occupy the top eight byte addresses; the rest is storage
// [RQ4] top down: year, month, date, weekday, hours, minutes, seconds in BCD, 24 hour
// [RQ5] date rolls over after 28, 29, 30 or 31 days; February leap years have 29
// [RQ6] lowest clock location is the control register, not a time field
// [RQ7] registers are storage apart from counters, refreshed once each second
// [RQ8] the per-second copy never stalls or corrupts other ram accesses
// [RQ9] power fail: ignore the bus, block writes, float data lines
// [RQ10] writes finish within a normal ram cycle, no write count limit
// [RQ11] software-written calibration setting trims the timekeeping rate
// [RQ12] read while write strobe high, chip enable low; ripple-through addressing
// [RQ13] write while strobe and enable both low, address held throughout
// [RQ14] during a write the output enable is ignored and outputs float
// [RQ15] control bit six held at one suspends the copy; resumes within a second
// [RQ16] clock registers decode at 0x7F8 (control) through 0x7FF (year)
`ifndef RTCRAM_PARAMS_SVH
`define RTCRAM_PARAMS_SVH

`define RTC_ADDR_W 11
`define RTC_RAM_WORDS 2048
`define RTC_CLK_BASE 11'h7F8
`define RTC_CTL_WRITE 7
`define RTC_CTL_READ 6
`define RTC_CTL_SIGN 5
`define RTC_CTL_CAL_HI 4
`define RTC_CTL_CAL_LO 0
`define RTC_CLK_PERIOD_NS 25
`define RTC_SECOND_NS 1000000000
`define RTC_CAL_STEP 2
`define RTC_RST_SEC 8'h00
`define RTC_RST_MIN 8'h00
`define RTC_RST_HOUR 8'h00
`define RTC_RST_WDAY 8'h01
`define RTC_RST_DATE 8'h01
`define RTC_RST_MONTH 8'h01
`define RTC_RST_YEAR 8'h00
`define RTC_RST_CTRL 8'h00
`define RTC_MAX_SEC 8'h59
`define RTC_MAX_MIN 8'h59
`define RTC_MAX_HOUR 8'h23
`define RTC_MAX_WDAY 8'h07
`define RTC_MAX_MONTH 8'h12
`define RTC_MAX_YEAR 8'h99
`define RTC_FEB 8'h02

`endif

// file: hw/rtcram_pkg.sv
// types shared by the calendar ram design
`default_nettype none
package rtcram_pkg;
  typedef logic [7:0] rtcram_byte_t;
  typedef logic [10:0] rtcram_addr_t;
  typedef enum logic [2:0] {
    RTCRAM_IDX_CTRL, RTCRAM_IDX_SEC, RTCRAM_IDX_MIN, RTCRAM_IDX_HOUR,
    RTCRAM_IDX_WDAY, RTCRAM_IDX_DATE, RTCRAM_IDX_MONTH, RTCRAM_IDX_YEAR
  } rtcram_idx_t;
endpackage : rtcram_pkg
`default_nettype wire

// file: hw/rtcram_bcd_ctr.sv
// one BCD time counter with wrap to a minimum value and parallel load
`default_nettype none
module rtcram_bcd_ctr
  import rtcram_pkg::*;
#(
  parameter rtcram_byte_t RST_VAL = 8'h00
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic inc,
  input wire logic load,
  input wire rtcram_byte_t load_val,
  input wire rtcram_byte_t min_val,
  input wire rtcram_byte_t max_val,
  output rtcram_byte_t val_q,
  output logic wrap
);
  // out-of-range values written by software also wrap on the next step
  assign wrap = inc && (val_q >= max_val);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      val_q <= RST_VAL;
    end else if (load) begin
      val_q <= load_val;
    end else if (wrap) begin
      val_q <= min_val;
    end else if (inc) begin
      if (val_q[3:0] == 4'h9) begin
        val_q <= {val_q[7:4] + 4'h1, 4'h0};
      end else begin
        val_q <= {val_q[7:4], val_q[3:0] + 4'h1};
      end
    end
  end
endmodule : rtcram_bcd_ctr
`default_nettype wire

// file: bench/rtcram_host.sv
// host processor model driving the byte-wide ram bus
`default_nettype none
module rtcram_host
  import rtcram_pkg::*;
(
  input wire logic clk,
  output rtcram_addr_t addr_in,
  output rtcram_byte_t data_bus_in,
  output logic chip_en_n,
  output logic write_en_n,
  output logic out_en_n,
  input wire rtcram_byte_t data_bus_out,
  input wire logic data_bus_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    addr_in = 11'h000;
    data_bus_in = 8'h00;
    chip_en_n = 1'b1;
    write_en_n = 1'b1;
    out_en_n = 1'b1;
  end
  // output enable stays low through the write, as in two-wire control
  task automatic wr(input rtcram_addr_t a, input rtcram_byte_t d, output logic oe);
    @(posedge clk);
    addr_in <= a;
    data_bus_in <= d;
    chip_en_n <= 1'b0;
    write_en_n <= 1'b0;
    out_en_n <= 1'b0;
    @(negedge clk);
    @(negedge clk);
    oe = data_bus_oe;
    @(posedge clk);
    chip_en_n <= 1'b1;
    write_en_n <= 1'b1;
    out_en_n <= 1'b1;
    // released lines must not keep showing the written byte
    data_bus_in <= ~d;
  endtask : wr
  task automatic rd(input rtcram_addr_t a, output rtcram_byte_t d, output logic oe);
    @(posedge clk);
    addr_in <= a;
    chip_en_n <= 1'b0;
    out_en_n <= 1'b0;
    @(negedge clk);
    @(negedge clk);
    d = data_bus_out;
    oe = data_bus_oe;
    @(posedge clk);
    chip_en_n <= 1'b1;
    out_en_n <= 1'b1;
  endtask : rd
endmodule : rtcram_host
`default_nettype wire

// file: bench/tb.sv
// self-checking bench for the calendar clock ram
`default_nettype none
module tb
  import rtcram_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic pf = 1'b0;
  rtcram_addr_t addr;
  rtcram_byte_t din, dout, got;
  logic oe, ce_n, we_n, oe_n, seen;
  int err_total = 0;
  int comparisons = 0;
  int cyc = 0;
  logic [31:0] rng = 32'd40;
  localparam int CPS = 100;
  // fastest trim with the sign bit set: full code 31, two cycles a step
  localparam int TRIM_PER = CPS - 31 * 2;
  always #12.5 clk = ~clk;
  rtcram_top #(.CYCLES_PER_SEC(CPS)) u_rtcram_top (
    .clk(clk), .rst(rst), .addr_in(addr), .data_bus_in(din), .data_bus_out(dout),
    .data_bus_oe(oe), .chip_en_n(ce_n), .write_en_n(we_n), .out_en_n(oe_n),
    .power_fail_trip(pf));
  rtcram_host u_rtcram_host (
    .clk(clk), .addr_in(addr), .data_bus_in(din), .chip_en_n(ce_n),
    .write_en_n(we_n), .out_en_n(oe_n), .data_bus_out(dout), .data_bus_oe(oe));
  function automatic logic [31:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction : rnd
  function automatic rtcram_byte_t inc(input rtcram_byte_t x, mx, mn);
    if (x == mx) return mn;
    return (x[3:0] == 4'h9) ? {x[7:4] + 4'h1, 4'h0} : x + 8'h01;
  endfunction : inc
  function automatic rtcram_byte_t last_day(input rtcram_byte_t m, y);
    case (m)
      8'h02: return (((y[7:4] * 10 + y[3:0]) % 4) == 0) ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
      default: return 8'h31;
    endcase
  endfunction : last_day
  function automatic int bcd2int(input rtcram_byte_t b);
    return int'(b[7:4]) * 10 + int'(b[3:0]);
  endfunction : bcd2int
  task automatic conclude();
    $display("mismatches %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude
  task automatic chk(input rtcram_byte_t g, e, input logic o, eo);
    comparisons++;
    if (o !== eo || (eo && g !== e)) begin
      err_total++;
      $display("unexpected at %0t: data %h oe %b, want %h oe %b", $time, g, o, e, eo);
    end
  endtask : chk
  task automatic rchk(input rtcram_addr_t a, input rtcram_byte_t e, input logic eo);
    u_rtcram_host.rd(a, got, seen);
    chk(got, e, seen, eo);
  endtask : rchk
  task automatic w(input rtcram_addr_t a, input rtcram_byte_t d);
    u_rtcram_host.wr(a, d, seen);
    chk(8'h00, 8'h00, seen, 1'b0);
  endtask : w
  task automatic traffic(input int n);
    rtcram_addr_t a;
    rtcram_byte_t d;
    repeat (n) begin
      a = rtcram_addr_t'(rnd() % 32'd2040);
      d = rtcram_byte_t'(rnd());
      w(a, d);
      rchk(a, d, 1'b1);
    end
  endtask : traffic
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      $display("unexpected at %0t: timeout", $time);
      err_total++;
      conclude();
    end
  end
  initial begin
    rtcram_byte_t y, m, d, ld, s0;
    rtcram_byte_t ex [8];
    rtcram_byte_t cs [5][3];
    cs = '{'{8'h03, 8'h02, 8'h28}, '{8'h04, 8'h02, 8'h28},
      '{8'h04, 8'h02, 8'h29}, '{8'h01, 8'h04, 8'h30}, '{8'h99, 8'h12, 8'h31}};
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    ex = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
    for (int i = 0; i < 8; i++) begin
      rchk(11'h7F8 + 11'(i), ex[i], 1'b1);
    end
    w(11'h000, 8'hA5);
    w(11'h7F7, 8'h5A);
    @(posedge clk);
    pf <= 1'b1;
    w(11'h000, 8'h3C);
    rchk(11'h000, 8'h00, 1'b0);
    @(posedge clk);
    pf <= 1'b0;
    rchk(11'h000, 8'hA5, 1'b1);
    rchk(11'h7F7, 8'h5A, 1'b1);
    // ram traffic long enough to overlap at least one per-second copy
    traffic(20);
    for (int c = 0; c < 5; c++) begin
      y = cs[c][0];
      m = cs[c][1];
      d = cs[c][2];
      ex = '{8'h80, 8'h59, 8'h59, 8'h23, 8'h07, d, m, y};
      for (int i = 0; i < 8; i++) begin
        w(11'h7F8 + 11'(i), ex[i]);
      end
      w(11'h7F8, 8'h00);
      got = 8'h59;
      for (int k = 0; k < 60 && got === 8'h59; k++) begin
        u_rtcram_host.rd(11'h7F9, got, seen);
      end
      w(11'h7F8, 8'h40);
      ld = last_day(m, y);
      ex = '{8'h40, 8'h00, 8'h00, 8'h00, 8'h01, (d == ld) ? 8'h01 : inc(d, 8'h31, 8'h01),
        (d == ld) ? inc(m, 8'h12, 8'h01) : m,
        (d == ld && m == 8'h12) ? inc(y, 8'h99, 8'h00) : y};
      // registers must stay frozen across a tick while ram traffic runs
      traffic(16);
      for (int i = 0; i < 8; i++) begin
        rchk(11'h7F8 + 11'(i), ex[i], 1'b1);
      end
      w(11'h7F8, 8'h00);
    end
    // shortest trimmed second: sync on a change, then count copies over nine periods
    w(11'h7F8, 8'h3F);
    u_rtcram_host.rd(11'h7F9, s0, seen);
    got = s0;
    for (int k = 0; k < 60 && got === s0; k++) begin
      u_rtcram_host.rd(11'h7F9, got, seen);
    end
    s0 = got;
    repeat (9 * TRIM_PER) @(posedge clk);
    u_rtcram_host.rd(11'h7F9, got, seen);
    comparisons++;
    if (seen !== 1'b1 || $isunknown(got) || (bcd2int(got) - bcd2int(s0) + 60) % 60 != 9) begin
      err_total++;
      $display("unexpected at %0t: trimmed seconds %h from %h", $time, got, s0);
    end
    conclude();
  end
endmodule : tb
`default_nettype wire
